// [bench/ccr_supervisor.sv]
// Purpose: external reset supervisor driving the reset pin
// Assumes: power_ok is the bench's view of the supply rails
// Notes: release delay is a parameter, so a slow supervisor can be modelled
`timescale 1ns/1ps
module ccr_supervisor #(
	parameter int DLY = 40
) (
	// clock
	input wire logic pclk,
	// supply and pin
	input wire logic power_ok,
	output logic reset_pin_n = 1'b0
);
	int cnt_q = 0;
	// ====
	// pin drive
	// low until powered and DLY cycles counted
	always @(posedge pclk) begin
		if (!power_ok) begin
			cnt_q <= 0;
		end else if (cnt_q != DLY) begin
			cnt_q <= cnt_q + 1;
		end
		reset_pin_n <= power_ok && cnt_q == DLY;
	end
endmodule : ccr_supervisor

// [bench/ccr_top_props.sv]
// Purpose: port-level checks for ccr_top
// Assumes: ce held high by the bench
// Notes: bound into every ccr_top instance
`timescale 1ns/1ps
module ccr_top_props #(
	parameter logic [13:0] POR_LOAD = ccr_pkg::POR_PRESET
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// clocks and status
	input wire logic main_tick,
	input wire logic pll_tick,
	input wire logic main_good,
	input wire logic reset_pin_n,
	input wire logic sys_tick,
	input wire logic aux1_tick,
	input wire logic aux2_tick,
	input wire logic pll_stop,
	input wire logic [2:0] pll_mult,
	input wire logic int_reset_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ====
	// sequences
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait_ready;
		!pready ##1 pready;
	endsequence
	sequence s_pd_clear;
		psel && penable && pready && pwrite && pstrb[0] && paddr == ccr_pkg::ADDR_CTRL && !pwdata[2];
	endsequence
	// ====
	// assertions
	AST_READY_WAIT: assert property (s_setup |=> s_wait_ready)
		else $error("pready late");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready held");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	AST_PD_CLEAR: assert property (s_pd_clear |-> ##[1:3] !pll_stop)
		else $error("pll not started");
	AST_MULT_LEGAL: assert property (pll_mult inside {3'h3, 3'h4, 3'h5})
		else $error("bad multiplier");
	AST_AUX1_GATE: assert property ((!main_good) [*6] |-> !aux1_tick)
		else $error("aux1 runs unstable");
	AST_AUX2_GATE: assert property ((!main_good) [*6] |-> !aux2_tick)
		else $error("aux2 runs unstable");
	AST_PIN_HOLD: assert property ((!reset_pin_n) [*5] |-> !int_reset_n)
		else $error("reset released early");
	AST_SYS_SOURCE: assert property (sys_tick |-> $past(main_tick, 2) || $past(pll_tick, 2))
		else $error("sys tick unsourced");
endmodule : ccr_top_props

bind ccr_top ccr_top_props #(.POR_LOAD(POR_LOAD)) u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .main_tick, .pll_tick, .main_good,
	.reset_pin_n, .sys_tick, .aux1_tick, .aux2_tick, .pll_stop, .pll_mult, .int_reset_n);

// [bench/tb_ccr_top.sv]
// Purpose: self-checking bench for ccr_top
// Assumes: ticks are made from pclk; ce and pstrb held high
// Notes: short POR_LOAD keeps the run brief
`timescale 1ns/1ps
`define CHK(a, e) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
	end \
end
module tb_ccr_top;
	localparam logic [31:0] AC = ccr_pkg::ADDR_CTRL;
	localparam logic [31:0] AF = ccr_pkg::ADDR_FAST;
	localparam logic [31:0] AS = ccr_pkg::ADDR_SLOW;
	localparam logic [31:0] AX = ccr_pkg::ADDR_AUX;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [31:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready, pslverr, sys_tick, slow_tick, aux1_tick, aux2_tick, pll_stop, int_reset_n;
	logic [2:0] pll_mult;
	logic main_tick = 0;
	logic pll_tick = 0;
	logic main_good = 1;
	logic pll_locked = 0;
	logic osc32_clk = 0;
	logic power_ok = 1;
	logic reset_pin_n;
	logic [7:0] rd;
	logic err;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 pclk = ~pclk;
	// main every second cycle, pll every cycle, slow oscillator every 16
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		main_tick <= cyc[0];
		pll_tick <= 1'b1;
		osc32_clk <= cyc[3];
	end
	ccr_top #(.POR_LOAD(14'h0010)) DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .main_tick, .pll_tick,
		.main_good, .pll_locked, .osc32_clk, .reset_pin_n, .sys_tick, .slow_tick, .aux1_tick,
		.aux2_tick, .pll_stop, .pll_mult, .int_reset_n);
	ccr_supervisor #(.DLY(40)) u_sup (.pclk, .power_ok, .reset_pin_n);
	// ====
	// helpers
	task automatic conclude;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			conclude();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rw(input logic [31:0] a, input logic [7:0] d, input logic [7:0] e);
		apb(1'b1, a, d);
		apb(1'b0, a, 8'h00);
		`CHK(rd, e)
	endtask : rw
	function automatic logic pick(input int w);
		case (w)
			0: return sys_tick;
			1: return slow_tick;
			2: return aux1_tick;
			default: return aux2_tick;
		endcase
	endfunction : pick
	// interval between ticks, after two settling periods
	task automatic per(input int w, input int e);
		int n;
		repeat (3) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (pick(w) !== 1'b1 && n < 300);
		end
		if (n >= 300) begin
			mismatches++;
			conclude();
		end
		`CHK(n, e)
	endtask : per
	task automatic quiet(input int w);
		logic [7:0] c;
		c = 0;
		repeat (40) begin
			@(posedge pclk);
			c = c + pick(w);
		end
		`CHK(c, 8'h00)
	endtask : quiet
	// ====
	// scenarios
	task automatic t_intreset;
		int n;
		`CHK(int_reset_n, 1'b0)
		n = 0;
		while (int_reset_n !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		`CHK(n > 36 && n < 200, 1'b1)
		power_ok <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK(int_reset_n, 1'b0)
		power_ok <= 1'b1;
		repeat (60) @(posedge pclk);
		`CHK(int_reset_n, 1'b1)
	endtask : t_intreset
	task automatic t_reset;
		logic [31:0] ad [4] = '{AC, AF, AS, AX};
		logic [7:0] ex [4] = '{8'h26, 8'h4f, 8'hb6, 8'hff};
		`CHK(pll_stop, 1'b1)
		`CHK(pll_mult, 3'h4)
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ad[i], 8'h00);
			`CHK(rd, ex[i])
		end
		apb(1'b0, 32'h0000_0000, 8'h00);
		`CHK(err, 1'b1)
	endtask : t_reset
	task automatic t_ctrl;
		rw(AC, 8'h26, 8'h26);
		rw(AC, 8'h06, 8'h06);
		rw(AC, 8'h26, 8'h06);
		rw(AC, 8'h04, 8'h06);
		rw(AC, 8'h02, 8'h02);
		repeat (3) @(posedge pclk);
		`CHK(pll_stop, 1'b0)
		rw(AC, 8'h00, 8'h02);
		pll_locked <= 1'b1;
		repeat (4) @(posedge pclk);
		rw(AC, 8'h00, 8'h00);
		rw(AC, 8'h04, 8'h00);
		`CHK(pll_stop, 1'b0)
		rw(AC, 8'h02, 8'h02);
		rw(AC, 8'hc6, 8'h06);
		repeat (3) @(posedge pclk);
		`CHK(pll_stop, 1'b1)
	endtask : t_ctrl
	task automatic t_mode;
		logic [2:0] md [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
		logic [2:0] mu [4] = '{3'h3, 3'h4, 3'h5, 3'h5};
		// prescaler written only off the pll
		for (int i = 0; i < 4; i++) begin
			rw(AF, {1'b1, md[i], 4'h1}, {1'b0, md[i], 4'h1});
			repeat (3) @(posedge pclk);
			`CHK(pll_mult, mu[i])
		end
		rw(AF, 8'h41, 8'h41);
	endtask : t_mode
	task automatic t_divs;
		per(0, 4);
		rw(AF, 8'h4f, 8'h4f);
		per(0, 32);
		rw(AF, 8'h41, 8'h41);
		rw(AS, 8'h01, 8'h01);
		per(1, 8);
		rw(AC, 8'h07, 8'h07);
		per(1, 16);
		rw(AX, 8'h10, 8'h10);
		rw(AC, 8'h1e, 8'h1e);
		per(2, 2);
		per(3, 4);
		main_good <= 1'b0;
		repeat (8) @(posedge pclk);
		quiet(2);
		quiet(3);
		main_good <= 1'b1;
		rw(AC, 8'h06, 8'h06);
		quiet(2);
		rw(AC, 8'h02, 8'h02);
		rw(AC, 8'h00, 8'h00);
		per(0, 2);
		rw(AC, 8'h02, 8'h02);
		per(0, 4);
	endtask : t_divs
	// ====
	// main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_intreset();
		t_reset();
		t_ctrl();
		t_mode();
		t_divs();
		conclude();
	end
endmodule : tb_ccr_top

// [inc/ccr_pkg.sv]
// Purpose: shared constants for the clock and reset control block
// Assumes: byte-wide registers, one per aligned apb word
// Notes: register index times four gives the byte address
package ccr_pkg;
	// ==========================================================
	// register indices and byte addresses
	localparam logic [23:0] IDX_CTRL = 24'hff_fc40;
	localparam logic [23:0] IDX_FAST = 24'hff_fc42;
	localparam logic [23:0] IDX_SLOW = 24'hff_fc44;
	localparam logic [23:0] IDX_AUX = 24'hff_fc46;
	localparam logic [31:0] ADDR_CTRL = {6'h00, IDX_CTRL, 2'h0};
	localparam logic [31:0] ADDR_FAST = {6'h00, IDX_FAST, 2'h0};
	localparam logic [31:0] ADDR_SLOW = {6'h00, IDX_SLOW, 2'h0};
	localparam logic [31:0] ADDR_AUX = {6'h00, IDX_AUX, 2'h0};

	// ==========================================================
	// control register fields
	localparam int BIT_SLOW_SEL = 0;
	localparam int BIT_FAST_SEL = 1;
	localparam int BIT_PLL_PD = 2;
	localparam int BIT_AUX1_EN = 3;
	localparam int BIT_AUX2_EN = 4;
	localparam int BIT_POR = 5;

	// fast prescaler fields
	localparam int FAST_DIV_LSB = 0;
	localparam int FAST_DIV_W = 4;
	localparam int FAST_MODE_LSB = 4;
	localparam int FAST_MODE_W = 3;
	// aux prescaler fields
	localparam int AUX1_DIV_LSB = 0;
	localparam int AUX2_DIV_LSB = 4;
	localparam int AUX_DIV_W = 4;
	localparam int SLOW_DIV_W = 8;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h26;
	localparam logic [7:0] RST_FAST = 8'h4f;
	localparam logic [7:0] RST_SLOW = 8'hb6;
	localparam logic [7:0] RST_AUX = 8'hff;
	localparam logic [7:0] CTRL_MASK = 8'h3f;
	localparam logic [7:0] FAST_MASK = 8'h7f;

	// ==========================================================
	// pll modes and multipliers
	localparam logic [2:0] MODE_X3 = 3'h3;
	localparam logic [2:0] MODE_X4 = 3'h4;
	localparam logic [2:0] MODE_X5 = 3'h5;
	localparam logic [2:0] MULT_X3 = 3'h3;
	localparam logic [2:0] MULT_X4 = 3'h4;
	localparam logic [2:0] MULT_X5 = 3'h5;

	// ==========================================================
	// power-on countdown
	localparam int POR_W = 14;
	localparam logic [13:0] POR_PRESET = 14'h3fff;

	typedef enum {SEL_CTRL, SEL_FAST, SEL_SLOW, SEL_AUX, SEL_NONE} ccr_sel_t;
endpackage : ccr_pkg

// [rtl/ccr_div.sv]
// Purpose: tick divider, one output tick per divisor plus one input ticks
// Assumes: tick_in is a one-cycle enable on the same clock
// Notes: disabling clears the count so a restart begins a full period
`timescale 1ns/1ps
module ccr_div #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// control
	input wire logic en,
	input wire logic tick_in,
	input wire logic [W-1:0] divisor,
	// output
	output logic tick_q
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} ccr_div_st_t;

	ccr_div_st_t s_q;
	ccr_div_st_t s_d;

	if (W < 1) begin : g_chk
		$error("ccr_div width must be at least one");
	end

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!en) begin
			s_d.cnt = '0;
		end else if (tick_in) begin
			if (s_q.cnt >= divisor) begin
				s_d.cnt = '0;
				s_d.tick = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign tick_q = s_q.tick;
endmodule : ccr_div

// [rtl/ccr_srcsw.sv]
// Purpose: switch between main and pll ticks without a shortened period
// Assumes: both ticks are one-cycle enables on the same clock
// Notes: a change lands at a tick of the old source, or when neither ticks
`timescale 1ns/1ps
module ccr_srcsw (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// sources
	input wire logic main_tick,
	input wire logic pll_tick,
	input wire logic sel_pll_req,
	// output
	output logic tick_q,
	output logic sel_pll_q
);
	// ==========================================================
	// state
	typedef struct packed {
		logic sel_pll;
		logic tick;
	} ccr_sw_st_t;

	ccr_sw_st_t s_q;
	ccr_sw_st_t s_d;

	always_comb begin
		s_d = s_q;
		// switch on a period boundary
		// a free-running fast source may never leave an idle cycle, so the
		// old source's own tick is also a safe boundary: its period is complete
		if (sel_pll_req != s_q.sel_pll
			&& ((s_q.sel_pll ? pll_tick : main_tick) || (!main_tick && !pll_tick))) begin
			s_d.sel_pll = sel_pll_req;
		end
		s_d.tick = s_q.sel_pll ? pll_tick : main_tick;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign tick_q = s_q.tick;
	assign sel_pll_q = s_q.sel_pll;
endmodule : ccr_srcsw

// [rtl/ccr_top.sv]
// Purpose: clock and reset control with apb registers
// Assumes: clocks are modelled as one-cycle tick enables on pclk
// Notes: pin-level status inputs pass a two-flop synchroniser
//
// Summary of operation
// - pll runs at main clock times three, four or five
// - fast select stays one until the pll is stable
// - writing one to fast select returns the source to main clock
// - selected source passes a divider of one to sixteen
// - aux clock one runs only when enabled and main clock stable
// - aux clock two runs only when enabled and main clock stable
// - 14-bit countdown from POR_LOAD (all ones by default) releases internal reset unless pin low
// - slow select chooses prescaled main clock or 32 kHz oscillator
// - fast select zero picks pll, one picks main clock; resets to one
// - clearing fast select is ignored while pll power-down is set
// - pll power-down bit holds the pll off; resets to one
// - setting power-down is ignored while fast select is zero
// - power-on flag sets on power-turn-on
// - software may clear power-on flag; writing one changes nothing
// - control bits: slow, fast, power-down, aux one, aux two, power-on
// - mode codes 011, 100, 101 give three, four, five; reset 100
// - system divider divides by field plus one
// - slow clock from main divides by two times field plus two
`timescale 1ns/1ps
module ccr_top #(
	parameter logic [13:0] POR_LOAD = ccr_pkg::POR_PRESET
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock sources, same domain ticks
	input wire logic main_tick,
	input wire logic pll_tick,
	// asynchronous status pins
	input wire logic main_good,
	input wire logic pll_locked,
	input wire logic osc32_clk,
	input wire logic reset_pin_n,
	// clock and control outputs
	output logic sys_tick,
	output logic slow_tick,
	output logic aux1_tick,
	output logic aux2_tick,
	output logic pll_stop,
	output logic [2:0] pll_mult,
	output logic int_reset_n
);
	// ==========================================================
	// decode helpers
	function automatic ccr_pkg::ccr_sel_t addr_sel(input logic [31:0] a);
		ccr_pkg::ccr_sel_t r;
		r = ccr_pkg::SEL_NONE;
		if (a == ccr_pkg::ADDR_CTRL) begin
			r = ccr_pkg::SEL_CTRL;
		end else if (a == ccr_pkg::ADDR_FAST) begin
			r = ccr_pkg::SEL_FAST;
		end else if (a == ccr_pkg::ADDR_SLOW) begin
			r = ccr_pkg::SEL_SLOW;
		end else if (a == ccr_pkg::ADDR_AUX) begin
			r = ccr_pkg::SEL_AUX;
		end
		return r;
	endfunction : addr_sel

	// reserved codes return zero, meaning keep the applied multiplier
	function automatic logic [2:0] mode_mult(input logic [2:0] m);
		logic [2:0] r;
		r = 3'h0;
		case (m)
			ccr_pkg::MODE_X3: r = ccr_pkg::MULT_X3;
			ccr_pkg::MODE_X4: r = ccr_pkg::MULT_X4;
			ccr_pkg::MODE_X5: r = ccr_pkg::MULT_X5;
			default: r = 3'h0;
		endcase
		return r;
	endfunction : mode_mult

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] fast;
		logic [7:0] slow;
		logic [7:0] aux;
		logic [2:0] mult;
		logic pll_stop;
		logic [1:0] good_s;
		logic [1:0] lock_s;
		logic [1:0] rpin_s;
		logic [2:0] osc_s;
		logic [13:0] por_cnt;
		logic int_rst_n;
		logic slow_tick;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ccr_st_t;

	ccr_st_t s_q;
	ccr_st_t s_d;

	localparam ccr_st_t ST_RESET = '{
		ctrl: ccr_pkg::RST_CTRL,
		fast: ccr_pkg::RST_FAST,
		slow: ccr_pkg::RST_SLOW,
		aux: ccr_pkg::RST_AUX,
		mult: ccr_pkg::MULT_X4,
		pll_stop: 1'b1,
		good_s: 2'h0,
		lock_s: 2'h0,
		rpin_s: 2'h0,
		osc_s: 3'h0,
		por_cnt: ccr_pkg::POR_PRESET,
		int_rst_n: 1'b0,
		slow_tick: 1'b0,
		prdata: 32'h0000_0000,
		pready: 1'b0,
		pslverr: 1'b0
	};

	if (POR_LOAD == 14'h0000) begin : g_chk
		$error("ccr_top power-on load must be non-zero");
	end

	// ==========================================================
	// submodule wires
	logic src_tick;
	logic src_is_pll;
	logic slow_div_tick;
	logic [1:0] aux_tick;
	logic main_ok;
	logic pll_ok;
	logic osc_edge;
	logic wr_fire;
	logic [7:0] wb;
	ccr_pkg::ccr_sel_t sel;

	assign main_ok = s_q.good_s[1];
	assign pll_ok = s_q.lock_s[1];
	assign osc_edge = s_q.osc_s[1] & ~s_q.osc_s[2];
	assign sel = addr_sel(paddr);
	assign wr_fire = psel & penable & s_q.pready & pwrite & pstrb[0];
	assign wb = pwdata[7:0];

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		// synchronisers; first stage feeds only the second
		s_d.good_s = {s_q.good_s[0], main_good};
		s_d.lock_s = {s_q.lock_s[0], pll_locked};
		s_d.rpin_s = {s_q.rpin_s[0], reset_pin_n};
		s_d.osc_s = {s_q.osc_s[1:0], osc32_clk};

		// apb: one wait state, answer registered
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (psel && penable && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.pslverr = (sel == ccr_pkg::SEL_NONE);
			case (sel)
				ccr_pkg::SEL_CTRL: s_d.prdata = {24'h00_0000, s_q.ctrl & ccr_pkg::CTRL_MASK};
				ccr_pkg::SEL_FAST: s_d.prdata = {24'h00_0000, s_q.fast & ccr_pkg::FAST_MASK};
				ccr_pkg::SEL_SLOW: s_d.prdata = {24'h00_0000, s_q.slow};
				ccr_pkg::SEL_AUX: s_d.prdata = {24'h00_0000, s_q.aux};
				default: s_d.prdata = 32'h0000_0000;
			endcase
		end

		if (wr_fire) begin
			case (sel)
				ccr_pkg::SEL_CTRL: begin
					s_d.ctrl[ccr_pkg::BIT_SLOW_SEL] = wb[ccr_pkg::BIT_SLOW_SEL];
					s_d.ctrl[ccr_pkg::BIT_AUX1_EN] = wb[ccr_pkg::BIT_AUX1_EN];
					s_d.ctrl[ccr_pkg::BIT_AUX2_EN] = wb[ccr_pkg::BIT_AUX2_EN];
					if (wb[ccr_pkg::BIT_FAST_SEL]) begin
						s_d.ctrl[ccr_pkg::BIT_FAST_SEL] = 1'b1;
					end else if (!s_q.ctrl[ccr_pkg::BIT_PLL_PD] && pll_ok) begin
						s_d.ctrl[ccr_pkg::BIT_FAST_SEL] = 1'b0;
					end
					if (!wb[ccr_pkg::BIT_PLL_PD]) begin
						s_d.ctrl[ccr_pkg::BIT_PLL_PD] = 1'b0;
					end else if (s_q.ctrl[ccr_pkg::BIT_FAST_SEL]) begin
						s_d.ctrl[ccr_pkg::BIT_PLL_PD] = 1'b1;
					end
					if (!wb[ccr_pkg::BIT_POR]) begin
						s_d.ctrl[ccr_pkg::BIT_POR] = 1'b0;
					end
				end
				ccr_pkg::SEL_FAST: s_d.fast = wb & ccr_pkg::FAST_MASK;
				ccr_pkg::SEL_SLOW: s_d.slow = wb;
				ccr_pkg::SEL_AUX: s_d.aux = wb;
				default: s_d.aux = s_q.aux;
			endcase
		end

		if (mode_mult(s_q.fast[ccr_pkg::FAST_MODE_LSB +: ccr_pkg::FAST_MODE_W]) != 3'h0) begin
			s_d.mult = mode_mult(s_q.fast[ccr_pkg::FAST_MODE_LSB +: ccr_pkg::FAST_MODE_W]);
		end
		s_d.pll_stop = s_q.ctrl[ccr_pkg::BIT_PLL_PD];

		s_d.slow_tick = s_q.ctrl[ccr_pkg::BIT_SLOW_SEL] ? osc_edge : slow_div_tick;

		if (main_ok && s_q.por_cnt != 14'h0000 && main_tick) begin
			s_d.por_cnt = s_q.por_cnt - 14'h0001;
		end
		s_d.int_rst_n = (s_q.por_cnt == 14'h0000) && s_q.rpin_s[1];
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= ST_RESET;
		end else if (ce) begin
			// countdown preset value is taken from the parameter after release
			if (s_q.int_rst_n == 1'b0 && s_q.por_cnt == ccr_pkg::POR_PRESET
				&& !s_q.good_s[1]) begin
				s_q <= s_d;
				s_q.por_cnt <= POR_LOAD;
			end else begin
				s_q <= s_d;
			end
		end
	end

	// ==========================================================
	// clock generation
	// glitch-free source switch
	ccr_srcsw u_sw (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.main_tick(main_tick),
		.pll_tick(pll_tick & ~s_q.pll_stop),
		.sel_pll_req(~s_q.ctrl[ccr_pkg::BIT_FAST_SEL]),
		.tick_q(src_tick),
		.sel_pll_q(src_is_pll)
	);

	ccr_div #(.W(ccr_pkg::FAST_DIV_W)) u_sys_div (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.en(1'b1),
		.tick_in(src_tick),
		.divisor(s_q.fast[ccr_pkg::FAST_DIV_LSB +: ccr_pkg::FAST_DIV_W]),
		.tick_q(sys_tick)
	);

	// divisor {n,1} gives two times n plus one
	ccr_div #(.W(ccr_pkg::SLOW_DIV_W + 1)) u_slow_div (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.en(~s_q.ctrl[ccr_pkg::BIT_SLOW_SEL]),
		.tick_in(main_tick),
		.divisor({s_q.slow, 1'b1}),
		.tick_q(slow_div_tick)
	);

	// two aux prescalers differ only in field and enable bit
	for (genvar i = 0; i < 2; i++) begin : g_aux
		ccr_div #(.W(ccr_pkg::AUX_DIV_W)) u_aux_div (
			.clk(pclk),
			.rst_n(presetn),
			.ce(ce),
			.en(s_q.ctrl[ccr_pkg::BIT_AUX1_EN + i] & main_ok),
			.tick_in(main_tick),
			.divisor(s_q.aux[ccr_pkg::AUX1_DIV_LSB + i * ccr_pkg::AUX_DIV_W +: ccr_pkg::AUX_DIV_W]),
			.tick_q(aux_tick[i])
		);
	end

	// ==========================================================
	// outputs
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign slow_tick = s_q.slow_tick;
	assign aux1_tick = aux_tick[0];
	assign aux2_tick = aux_tick[1];
	assign pll_stop = s_q.pll_stop;
	assign pll_mult = s_q.mult;
	assign int_reset_n = s_q.int_rst_n;
endmodule : ccr_top
